// ---- rtl/ssmc_top.sv ----
// Startup sequencer, mode control and output gating with APB access
// ---------------------------------------------------------------
// Behaviour
// - Only normal, command and diagnostic working modes
// - Hold reset phase, output high impedance
// - Configuration load phase, output lower range
// - Optional ROM check phase, output lower range
// - Five conversions; output per output mode
// - Startup error enters diagnostic mode (code ignores faults during the hold reset phase)
// - After startup, enable conditioned output
// - Windowed mode: analog only after quiet window
// - Result is unsigned fifteen-bit fraction
// - Analog value clipped to programmed limits
// - Conditioning corrects offset, temperature, nonlinearity (code removes offset only)
// - Digital-only: analog off, wire readout on
// - Command entry accepted only inside window
// - Analog-only: wire readout refused
// - Failure: diagnostic, lower range, error code
// - Watchdog and oscillator failures raise failure
// - Memory and register parity errors raise failure
// - Sensor wiring and common-mode drift checks
// - Phase times counted in oscillator cycles
// - Conversion time two^res over half oscillator
// ---------------------------------------------------------------
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ssmc_consts.svh"

module ssmc_top #(
   parameter int POR_OSC = `SSMC_POR_OSC,
   parameter int CFG_OSC = `SSMC_CFG_OSC,
   parameter int ROM_OSC = `SSMC_ROM_OSC,
   parameter int WIN_OSC = `SSMC_WIN_OSC,
   parameter int PCLK_PER_OSC = `SSMC_PCLK_PER_OSC
) (
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Conditioning data path
   input  wire logic [15:0] raw_signal,
   input  wire logic        raw_valid,
   // Failsafe monitors (asynchronous to pclk)
   input  wire logic [7:0]  fault_in,
   // Single wire link activity and command entry
   input  wire logic        wire_activity,
   input  wire logic        enter_command_request,
   input  wire logic        wire_read_req,
   // Output pin control
   output logic             analog_output_en,
   output logic             lower_diag_range,
   output logic [14:0]      analog_value,
   output logic             wire_read_ok,
   output logic [15:0]      wire_read_data,
   // Working mode indication
   output logic             normal_operation,
   output logic             calibration_command_mode,
   output logic             diagnostic_mode
);
   // ------------------------------------------------------------
   // Oscillator tick: phase timing scales with oscillator rate
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      PH_POR, PH_CFG, PH_ROM, PH_MEAS, PH_RUN, PH_DIAG
   } ssmc_phase_type;

   ssmc_phase_type phase_reg, phase_next;
   logic [7:0]  osc_div_reg;
   logic        osc_tick;
   logic [20:0] cnt_reg, cnt_next;
   logic [20:0] win_reg;
   logic        win_open_reg;
   logic        wire_seen_reg;
   logic        cmd_mode_reg;

   assign osc_tick = (osc_div_reg == 8'(PCLK_PER_OSC - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) osc_div_reg <= 8'h00;
      else osc_div_reg <= osc_tick ? 8'h00 : osc_div_reg + 8'h01;
   end

   // ------------------------------------------------------------
   // Synchronisers for outside inputs
   // ------------------------------------------------------------
   logic [7:0] f_s1, f_s2, f_s3;
   logic [2:0] w_s1, w_s2, w_s3;
   logic [7:0] fault_sync;
   logic [2:0] wire_sync;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         f_s1 <= 8'h00;
         f_s2 <= 8'h00;
         f_s3 <= 8'h00;
         w_s1 <= 3'h0;
         w_s2 <= 3'h0;
         w_s3 <= 3'h0;
      end else begin
         f_s1 <= fault_in;
         f_s2 <= f_s1;
         f_s3 <= f_s2;
         w_s1 <= {wire_read_req, enter_command_request, wire_activity};
         w_s2 <= w_s1;
         w_s3 <= w_s2;
      end
   end

   // A change counts once stages two and three agree
   logic [7:0] fault_agree_reg;
   logic [2:0] wire_agree_reg;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_fault
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) fault_agree_reg[gi] <= 1'b0;
            else if (f_s2[gi] == f_s3[gi]) fault_agree_reg[gi] <= f_s3[gi];
         end
      end
      for (gi = 0; gi < 3; gi++) begin : g_wire
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) wire_agree_reg[gi] <= 1'b0;
            else if (w_s2[gi] == w_s3[gi]) wire_agree_reg[gi] <= w_s3[gi];
         end
      end
   endgenerate
   assign fault_sync = fault_agree_reg;
   assign wire_sync  = wire_agree_reg;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0]  ctrl_reg;
   logic [14:0] lim_lo_reg, lim_hi_reg;
   logic [7:0]  fault_sticky_reg;
   logic [15:0] offset_reg;
   logic [15:0] result_reg;
   logic        sw_cmd_reg;

   wire wr_en = psel & penable & pwrite;
   wire rd_en = psel & penable & ~pwrite;
   wire hit_ctrl   = (paddr == `SSMC_A_CTRL);
   wire hit_stat   = (paddr == `SSMC_A_STAT);
   wire hit_result = (paddr == `SSMC_A_RESULT);
   wire hit_limits = (paddr == `SSMC_A_LIMITS);
   wire hit_fault  = (paddr == `SSMC_A_FAULT);
   wire hit_cmd    = (paddr == `SSMC_A_CMD);
   wire hit_any    = hit_ctrl | hit_stat | hit_result | hit_limits |
                     hit_fault | hit_cmd;

   ssmc_pkg::ssmc_omode_type omode;
   assign omode = ssmc_pkg::ssmc_omode_type'(
      ctrl_reg[`SSMC_C_OMODE_HI:`SSMC_C_OMODE_LO]);
   wire rom_check_enable = ctrl_reg[`SSMC_C_ROMCHK];
   wire res14            = ctrl_reg[`SSMC_C_RES14];
   // Control register is writable until startup leaves config phase, and again in command mode; limits and offset only in command mode
   wire cfg_locked = (phase_reg != PH_POR) && (phase_reg != PH_CFG);

   // Software command request writes key; taken only in window
   wire sw_cmd_write = wr_en & hit_cmd & (pwdata[7:0] == `SSMC_CMD_KEY);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg   <= `SSMC_CTRL_RST;
         lim_lo_reg <= `SSMC_LIM_LO_RST;
         lim_hi_reg <= `SSMC_LIM_HI_RST;
         offset_reg <= 16'h0000;
      end else if (wr_en && hit_ctrl && (!cfg_locked || cmd_mode_reg)) begin
         ctrl_reg <= pwdata[7:0];
      end else if (wr_en && hit_limits && cmd_mode_reg) begin
         lim_lo_reg <= pwdata[14:0];
         lim_hi_reg <= pwdata[30:16];
      end else if (wr_en && hit_fault && cmd_mode_reg) begin
         offset_reg <= pwdata[31:16];
      end
   end

   // Sticky failure flags; hardware set wins over any later action
   wire any_fault = |fault_sync;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) fault_sticky_reg <= 8'h00;
      else fault_sticky_reg <= fault_sticky_reg | fault_sync;
   end

   // ------------------------------------------------------------
   // Startup sequencer
   // ------------------------------------------------------------
   // Five conversions of 2^res oscillator cycles times two
   wire [20:0] meas_osc = res14 ?
      21'((`SSMC_ADC_CONV_COUNT << (`SSMC_RES14 + 1))) :
      21'((`SSMC_ADC_CONV_COUNT << (`SSMC_RES13 + 1)));

   wire cnt_done = osc_tick && (cnt_reg == 21'h000000);

   always_comb begin
      phase_next = phase_reg;
      cnt_next   = cnt_reg;
      if (osc_tick && cnt_reg != 21'h000000) cnt_next = cnt_reg - 21'h1;
      if (phase_reg != PH_POR && phase_reg != PH_DIAG && any_fault) begin
         phase_next = PH_DIAG;
      end else begin
         unique case (phase_reg)
            PH_POR: if (cnt_done) begin
               phase_next = PH_CFG;
               cnt_next   = 21'(CFG_OSC - 1);
            end
            PH_CFG: if (cnt_done) begin
               if (rom_check_enable) begin
                  phase_next = PH_ROM;
                  cnt_next   = 21'(ROM_OSC - 1);
               end else begin
                  phase_next = PH_MEAS;
                  cnt_next   = meas_osc - 21'h1;
               end
            end
            PH_ROM: if (cnt_done) begin
               phase_next = PH_MEAS;
               cnt_next   = meas_osc - 21'h1;
            end
            PH_MEAS: if (cnt_done) phase_next = PH_RUN;
            PH_RUN:  phase_next = PH_RUN;
            PH_DIAG: phase_next = PH_DIAG;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg <= PH_POR;
         cnt_reg   <= 21'(POR_OSC - 1);
      end else begin
         phase_reg <= phase_next;
         cnt_reg   <= cnt_next;
      end
   end

   // ------------------------------------------------------------
   // Command-entry window, opened when startup finishes
   // ------------------------------------------------------------
   wire win_start = (phase_reg == PH_MEAS) && (phase_next == PH_RUN);
   wire cmd_req   = wire_sync[1] | sw_cmd_write;
   wire cmd_take  = win_open_reg && cmd_req &&
                    (omode == ssmc_pkg::SSMC_OM_WINDOW ||
                     omode == ssmc_pkg::SSMC_OM_WIRE_ANA);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_open_reg  <= 1'b0;
         win_reg       <= 21'h000000;
         wire_seen_reg <= 1'b0;
         cmd_mode_reg  <= 1'b0;
         sw_cmd_reg    <= 1'b0;
      end else begin
         sw_cmd_reg <= sw_cmd_write;
         if (win_start) begin
            win_open_reg <= 1'b1;
            win_reg      <= 21'(WIN_OSC - 1);
         end else if (win_open_reg && osc_tick) begin
            if (win_reg == 21'h000000) win_open_reg <= 1'b0;
            else win_reg <= win_reg - 21'h1;
         end
         if (win_open_reg && wire_sync[0]) wire_seen_reg <= 1'b1;
         if (phase_reg == PH_DIAG) cmd_mode_reg <= 1'b0;
         else if (cmd_take) cmd_mode_reg <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Conditioning: offset removal, clip to unsigned fraction
   // ------------------------------------------------------------
   wire [16:0] corr = {1'b0, raw_signal} - {1'b0, offset_reg};
   wire [14:0] frac = corr[16] ? 15'h0000 :
                      (corr[15] ? 15'h7FFF : corr[14:0]);
   wire [14:0] clipped = (frac < lim_lo_reg) ? lim_lo_reg :
                         (frac > lim_hi_reg) ? lim_hi_reg : frac;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) result_reg <= 16'h0000;
      else if (raw_valid && phase_reg == PH_RUN)
         result_reg <= {1'b0, frac};
   end

   // ------------------------------------------------------------
   // Pin gating
   // ------------------------------------------------------------
   ssmc_pkg::ssmc_pin_type pin_state;
   wire tri_modes = (omode == ssmc_pkg::SSMC_OM_WINDOW) ||
                    (omode == ssmc_pkg::SSMC_OM_DIG_ONLY);
   wire win_ok    = !win_open_reg && !wire_seen_reg && !cmd_mode_reg;
   assign pin_state =
      (phase_reg == PH_POR) ? ssmc_pkg::SSMC_PIN_HIZ :
      (phase_reg == PH_DIAG) ? ssmc_pkg::SSMC_PIN_LDR :
      (phase_reg == PH_MEAS) ?
         (tri_modes ? ssmc_pkg::SSMC_PIN_HIZ : ssmc_pkg::SSMC_PIN_LDR) :
      (phase_reg != PH_RUN) ? ssmc_pkg::SSMC_PIN_LDR :
      (omode == ssmc_pkg::SSMC_OM_DIG_ONLY) ? ssmc_pkg::SSMC_PIN_HIZ :
      (omode == ssmc_pkg::SSMC_OM_WINDOW && !win_ok) ?
         ssmc_pkg::SSMC_PIN_HIZ : ssmc_pkg::SSMC_PIN_ANALOG;
   // the wire master overdrives the limited analog driver

   wire wire_rd_allow = (omode != ssmc_pkg::SSMC_OM_ANA_ONLY);
   wire [15:0] read_word = (phase_reg == PH_DIAG) ? `SSMC_ERR_CODE :
                           result_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_output_en <= 1'b0;
         lower_diag_range <= 1'b0;
         analog_value     <= 15'h0000;
         wire_read_ok     <= 1'b0;
         wire_read_data   <= 16'h0000;
         normal_operation <= 1'b0;
         calibration_command_mode <= 1'b0;
         diagnostic_mode  <= 1'b0;
      end else begin
         analog_output_en <= (pin_state != ssmc_pkg::SSMC_PIN_HIZ);
         lower_diag_range <= (pin_state == ssmc_pkg::SSMC_PIN_LDR);
         analog_value     <= (pin_state == ssmc_pkg::SSMC_PIN_ANALOG) ?
                             clipped : 15'h0000;
         wire_read_ok     <= wire_sync[2] && wire_rd_allow &&
                             phase_reg inside {PH_RUN, PH_DIAG};
         wire_read_data   <= (wire_sync[2] && wire_rd_allow) ?
                             read_word : 16'h0000;
         // exactly one of three working modes once started
         normal_operation <= (phase_reg == PH_RUN) && !cmd_mode_reg;
         calibration_command_mode <= (phase_reg == PH_RUN) && cmd_mode_reg;
         diagnostic_mode  <= (phase_reg == PH_DIAG);
      end
   end

   // ------------------------------------------------------------
   // APB read path, zero wait states
   // ------------------------------------------------------------
   wire [31:0] stat_word = {16'h0000, 7'h00, phase_reg, wire_seen_reg,
                            win_open_reg, cmd_mode_reg, sw_cmd_reg,
                            (phase_reg == PH_DIAG), (phase_reg == PH_RUN)};
   wire [31:0] rd_mux =
      hit_ctrl   ? {24'h000000, ctrl_reg} :
      hit_stat   ? stat_word :
      hit_result ? {16'h0000, read_word} :
      hit_limits ? {1'b0, lim_hi_reg, 1'b0, lim_lo_reg} :
      hit_fault  ? {offset_reg, 8'h00, fault_sticky_reg} : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : prdata;
         pslverr <= psel & ~penable & ~hit_any;
      end
   end
   wire unused_ok = rd_en;
endmodule // ssmc_top
`default_nettype wire

// ---- rtl/ssmc_consts.svh ----
// Constants for the sensor startup and mode control sequencer
`ifndef SSMC_CONSTS_SVH
`define SSMC_CONSTS_SVH
// ---------------------------------------------------------------
// Timing (nominal oscillator 3 MHz, core clock 250 MHz)
// ---------------------------------------------------------------
`define SSMC_OSC_HZ          3000000
`define SSMC_CLK_HZ          250000000
`define SSMC_PCLK_PER_OSC    83
`define SSMC_POR_MIN_US      500
`define SSMC_POR_OSC         1500
`define SSMC_CFG_US          200
`define SSMC_CFG_OSC         600
`define SSMC_ROM_MS          10
`define SSMC_ROM_OSC         30000
`define SSMC_WIN_MS          500
`define SSMC_WIN_OSC         1500000
`define SSMC_ADC_CONV_COUNT  5
`define SSMC_RES13           13
`define SSMC_RES14           14
// ---------------------------------------------------------------
// APB register map
// ---------------------------------------------------------------
`define SSMC_A_CTRL          12'h000
`define SSMC_A_STAT          12'h004
`define SSMC_A_RESULT        12'h008
`define SSMC_A_LIMITS        12'h00C
`define SSMC_A_FAULT         12'h010
`define SSMC_A_CMD           12'h014
`define SSMC_ERR_CODE        16'hFFFF
`define SSMC_LIM_LO_RST      15'h0CCD
`define SSMC_LIM_HI_RST      15'h7333
`define SSMC_CTRL_RST        8'h00
`define SSMC_CMD_KEY         8'hA5
// Control field positions
`define SSMC_C_ROMCHK        0
`define SSMC_C_RES14         1
`define SSMC_C_OMODE_LO      2
`define SSMC_C_OMODE_HI      3
`define SSMC_C_START         4
`define SSMC_FAULT_BITS      8
`endif

// ---- rtl/ssmc_pkg.sv ----
// Types for the sensor startup and mode control sequencer
package ssmc_pkg;
   typedef enum logic [1:0] {
      SSMC_OM_WIRE_ANA,
      SSMC_OM_ANA_ONLY,
      SSMC_OM_WINDOW,
      SSMC_OM_DIG_ONLY
   } ssmc_omode_type;
   typedef enum logic [1:0] {
      SSMC_PIN_HIZ,
      SSMC_PIN_LDR,
      SSMC_PIN_ANALOG
   } ssmc_pin_type;
endpackage

// ---- sim/ssmc_top_assertions.sv ----
// Concurrent checks on the ports of the startup and mode sequencer
`timescale 1ns/100ps
`default_nettype none
`include "ssmc_consts.svh"

module ssmc_top_assertions #(
   parameter int POR_OSC      = `SSMC_POR_OSC,
   parameter int CFG_OSC      = `SSMC_CFG_OSC,
   parameter int ROM_OSC      = `SSMC_ROM_OSC,
   parameter int WIN_OSC      = `SSMC_WIN_OSC,
   parameter int PCLK_PER_OSC = `SSMC_PCLK_PER_OSC
) (
   // APB slave
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Data path and monitors
   input wire logic [15:0] raw_signal,
   input wire logic        raw_valid,
   input wire logic [7:0]  fault_in,
   // Single wire link
   input wire logic        wire_activity,
   input wire logic        enter_command_request,
   input wire logic        wire_read_req,
   // Pin control and modes
   input wire logic        analog_output_en,
   input wire logic        lower_diag_range,
   input wire logic [14:0] analog_value,
   input wire logic        wire_read_ok,
   input wire logic [15:0] wire_read_data,
   input wire logic        normal_operation,
   input wire logic        calibration_command_mode,
   input wire logic        diagnostic_mode
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_modes_exclusive: assert property (
      $onehot0({normal_operation, calibration_command_mode, diagnostic_mode}))
      else $error("more than one working mode active");
   a_por_hiz: assert property (
      $rose(presetn) |-> (!analog_output_en && !lower_diag_range) [*4])
      else $error("pin driven during reset phase");
   a_normal_exit: assert property (
      normal_operation |=> normal_operation || calibration_command_mode
                           || diagnostic_mode)
      else $error("normal operation dropped without a new mode");
   a_fault_diag: assert property (
      normal_operation && (fault_in != 8'h00) |-> ##[1:8] diagnostic_mode)
      else $error("monitor fault did not raise diagnostic mode");
   a_diag_sticky: assert property (
      diagnostic_mode |=> diagnostic_mode)
      else $error("diagnostic mode left before reset");
   a_diag_ldr: assert property (
      diagnostic_mode [*3] |-> lower_diag_range && !normal_operation)
      else $error("diagnostic mode without lower range");
   a_err_code: assert property (
      diagnostic_mode [*3] ##0 wire_read_ok |->
         wire_read_data == `SSMC_ERR_CODE)
      else $error("wire read in diagnostic mode lacks error code");
   a_frac_range: assert property (
      wire_read_ok && !diagnostic_mode |-> !wire_read_data[15])
      else $error("result outside fifteen bit fraction");
   // Holds only while the limits keep their reset values
   a_clip_limits: assert property (
      analog_output_en && !lower_diag_range |->
         analog_value >= `SSMC_LIM_LO_RST && analog_value <= `SSMC_LIM_HI_RST)
      else $error("analog value outside output limits");

   c_analog_on: cover property (normal_operation && analog_output_en);
   c_diag_entry: cover property ($rose(diagnostic_mode));
   c_refused: cover property (pready && pslverr);
endmodule // ssmc_top_assertions
`default_nettype wire

// ---- sim/ssmc_wire_master.sv ----
// Model of the external calibration master on the single wire link
`timescale 1ns/100ps
`default_nettype none

module ssmc_wire_master #(
   parameter int GAP = 2
) (
   // Clock
   input  wire logic pclk,
   // Link levels seen by the device
   output var logic  wire_activity,
   output var logic  enter_command_request,
   output var logic  wire_read_req
);
   initial begin
      wire_activity = 1'h0;
      enter_command_request = 1'h0;
      wire_read_req = 1'h0;
   end

   // Activity spans the whole command: the master overdrives the
   // current-limited pin so the analog driver cannot corrupt it
   task automatic send_command(input int slow);
      wire_activity <= 1'h1;
      repeat (GAP + slow) @(posedge pclk);
      enter_command_request <= 1'h1;
      repeat (4 + slow) @(posedge pclk);
      enter_command_request <= 1'h0;
      wire_activity <= 1'h0;
      @(posedge pclk);
   endtask

   task automatic start_read();
      wire_read_req <= 1'h1;
   endtask

   task automatic stop_read();
      wire_read_req <= 1'h0;
   endtask
endmodule // ssmc_wire_master
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the sensor startup and mode sequencer
`timescale 1ns/100ps
`default_nettype none
`include "ssmc_consts.svh"
`define CHK(act, exp) begin \
   cmp_count++; \
   if ((act) !== (exp)) begin \
      fail_count++; \
      $display("CHECK FAILED t=%0t got %0h want %0h", $time, act, exp); \
   end \
end

module tb_top;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic        pclk = 1'h0;
   logic        presetn = 1'h0;
   logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err;
   logic [15:0] raw_signal = 16'h0000, wire_read_data;
   logic        raw_valid = 1'h0;
   logic [7:0]  fault_in = 8'h00;
   logic        wire_activity, enter_command_request, wire_read_req;
   logic        analog_output_en, lower_diag_range, wire_read_ok;
   logic [14:0] analog_value;
   logic        normal_operation, calibration_command_mode, diagnostic_mode;
   int          fail_count = 0;
   int          cmp_count = 0;

   always #2 pclk = ~pclk;

   // ROM check and window shortened; other phases keep full length
   ssmc_top #(.ROM_OSC(8), .WIN_OSC(20),
      .PCLK_PER_OSC(1)) ssmc_top_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .raw_signal(raw_signal),
      .raw_valid(raw_valid), .fault_in(fault_in),
      .wire_activity(wire_activity),
      .enter_command_request(enter_command_request),
      .wire_read_req(wire_read_req), .analog_output_en(analog_output_en),
      .lower_diag_range(lower_diag_range), .analog_value(analog_value),
      .wire_read_ok(wire_read_ok), .wire_read_data(wire_read_data),
      .normal_operation(normal_operation),
      .calibration_command_mode(calibration_command_mode),
      .diagnostic_mode(diagnostic_mode));

   ssmc_wire_master ssmc_wire_master_inst (.pclk(pclk),
      .wire_activity(wire_activity),
      .enter_command_request(enter_command_request),
      .wire_read_req(wire_read_req));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 40);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         fail_count++;
         report_and_stop();
      end
      @(posedge pclk);
   endtask

   // Selector: 0 normal operation, 1 diagnostic mode, 2 lower range
   task automatic wait_on(input int which, input int lim);
      int n;
      logic [2:0] v;
      n = 0;
      while (n < lim) begin
         v = {normal_operation, diagnostic_mode, lower_diag_range};
         if (v[2 - which] === 1'h1) break;
         @(posedge pclk);
         n++;
      end
      if (n >= lim) begin
         fail_count++;
         $display("CHECK FAILED t=%0t wait ran out", $time);
         report_and_stop();
      end
   endtask

   task automatic do_reset();
      presetn <= 1'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
   endtask

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      do_reset();
      `CHK(analog_output_en, 1'h0)
      // Windowed mode, ROM check on, 13-bit conversions
      apb(1'h1, `SSMC_A_CTRL, 32'h0000_0009);
      wait_on(2, 1600);
      `CHK(diagnostic_mode, 1'h0)
      repeat (600) @(posedge pclk);
      `CHK(lower_diag_range, 1'h1)
      repeat (20) @(posedge pclk);
      `CHK({analog_output_en, lower_diag_range}, 2'h0)
      wait_on(0, 90000);
      `CHK(analog_output_en, 1'h0)
      repeat (40) @(posedge pclk);
      `CHK(analog_output_en, 1'h1)
      for (int i = 0; i < 2; i++) begin
         raw_signal <= (i == 0) ? 16'h0000 : 16'hFFFF;
         raw_valid <= 1'h1;
         @(posedge pclk);
         raw_valid <= 1'h0;
         repeat (6) @(posedge pclk);
         `CHK(analog_value >= `SSMC_LIM_LO_RST && analog_value <= `SSMC_LIM_HI_RST, 1'h1)
         apb(1'h0, `SSMC_A_RESULT, 32'h0);
         `CHK(rd[31:15], 17'h0)
      end
      // Wire readout in normal operation: saturated fraction
      ssmc_wire_master_inst.start_read();
      repeat (6) @(posedge pclk);
      `CHK({wire_read_ok, wire_read_data}, {1'h1, 16'h7FFF})
      ssmc_wire_master_inst.stop_read();
      // Entry requests after the window, prompt and slow, are refused
      ssmc_wire_master_inst.send_command(0);
      ssmc_wire_master_inst.send_command(6);
      repeat (8) @(posedge pclk);
      `CHK(calibration_command_mode, 1'h0)
      apb(1'h0, 12'h0FC, 32'h0);
      `CHK({err, rd}, {1'h1, 32'h0})
      fault_in <= 8'h01;
      wait_on(1, 20);
      `CHK({lower_diag_range, normal_operation}, 2'h2)
      ssmc_wire_master_inst.start_read();
      repeat (6) @(posedge pclk);
      `CHK(wire_read_data, `SSMC_ERR_CODE)
      ssmc_wire_master_inst.stop_read();
      fault_in <= 8'h00;
      repeat (10) @(posedge pclk);
      `CHK(diagnostic_mode, 1'h1)
      // Each monitor input, analog-only mode, fault during configuration
      for (int b = 0; b < 8; b++) begin
         do_reset();
         apb(1'h1, `SSMC_A_CTRL, 32'h0000_0004);
         repeat (1530) @(posedge pclk);
         `CHK({lower_diag_range, diagnostic_mode}, 2'h2)
         fault_in <= 8'h01 << b;
         wait_on(1, 20);
         `CHK({normal_operation, lower_diag_range}, 2'h1)
         fault_in <= 8'h00;
      end
      report_and_stop();
   end
endmodule // tb_top

bind ssmc_top ssmc_top_assertions #(.POR_OSC(POR_OSC), .CFG_OSC(CFG_OSC),
   .ROM_OSC(ROM_OSC), .WIN_OSC(WIN_OSC), .PCLK_PER_OSC(PCLK_PER_OSC))
   ssmc_top_assertions_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .raw_signal(raw_signal), .raw_valid(raw_valid), .fault_in(fault_in),
   .wire_activity(wire_activity),
   .enter_command_request(enter_command_request),
   .wire_read_req(wire_read_req), .analog_output_en(analog_output_en),
   .lower_diag_range(lower_diag_range), .analog_value(analog_value),
   .wire_read_ok(wire_read_ok), .wire_read_data(wire_read_data),
   .normal_operation(normal_operation),
   .calibration_command_mode(calibration_command_mode),
   .diagnostic_mode(diagnostic_mode));
`default_nettype wire
